// ==== verilog/smi_pkg.sv ====
// smi_pkg: shared constants and carrier types of the serial memory slave
// assumes a single 100 MHz clock domain in every module that uses it
package smi_pkg;
    // ------------------------------------------------------------
    // geometry and address word layout
    // ------------------------------------------------------------
    localparam int ADDR_W      = 15;
    localparam int DATA_W      = 8;
    localparam int TYPE_POS    = 4;
    localparam int SEL_POS     = 1;
    localparam int DIR_POS     = 0;
    localparam int BITS_UNIT   = 8;
    localparam int FIFO_DEPTH  = 8;
    localparam logic [3:0] TYPE_CODE = 4'h6; // type code, value arbitrary
    localparam logic [3:0] BIT_CNT_RST = 4'h0;

    // ------------------------------------------------------------
    // serial engine states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        SMI_IDLE   = 7'h01,
        SMI_DEVADR = 7'h02,
        SMI_ADRHI  = 7'h04,
        SMI_ADRLO  = 7'h08,
        SMI_WDATA  = 7'h10,
        SMI_RDATA  = 7'h20,
        SMI_RACK   = 7'h40
    } smi_state_t;

    // one memory write request carried through the fifo
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } smi_wreq_t;
endpackage

// ==== verilog/smi_fifo.sv ====
// smi_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module smi_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    // fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // drain side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             do_wr;
    logic             do_rd;

    // honest full/empty from the extra pointer bit
    assign in_ready_out  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_ptr != rd_ptr;
    assign out_data_out  = mem[rd_ptr[AW-1:0]];
    assign do_wr = in_valid_in && in_ready_out;
    assign do_rd = out_valid_out && out_ready_in;

    // storage
    always_ff @(posedge sys_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    // pointers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // smi_fifo

// ==== verilog/smi_slave.sv ====
// smi_slave: two-wire serial slave in front of a 32K x 8 byte array
// assumes scl/sda/select/protect pins are asynchronous to sys_clk_in and
// that the bus master keeps scl slow against the 100 MHz clock
//
// Functional notes
// (RULE_01) units are 8 bits; receiver pulls data low on 9th clock
// (RULE_02) transmitter releases data line during the 9th clock
// (RULE_03) stop before acknowledge abandons the operation, back to standby
// (RULE_04) after a not-acknowledge the device releases the bus
// (RULE_05) address word: type code, select 2..0, direction flag
// (RULE_06) wrong type or select code: standby, no acknowledge
// (RULE_07) respond only if select code equals strapped select pins
// (RULE_08) 8th address bit: 0 write, 1 read
// (RULE_09) two address bytes, high first, each acknowledged
// (RULE_10) master sends zero in address bit 15
// (RULE_11) write: take 8 bits and ack; read: drive 8, await ack
// (RULE_12) address word acknowledged at once, no polling wait
// (RULE_13) protect high blocks all writes; reads always work
// (RULE_14) byte write: address word, two address bytes, data, stop
// (RULE_15) further bytes go to next address, wrapping to zero
// (RULE_16) data committed right after its acknowledge completes
// (RULE_17) current-address read returns byte after last accessed
// (RULE_18) pointer has no reset value and persists between frames
// (RULE_19) random read: load address, repeated start, read one byte
// (RULE_20) master answers final read byte with not-acknowledge
// (RULE_21) acknowledged reads keep sending successive wrapped bytes
// (RULE_22) master alone drives serial clock
// (RULE_23) sample on rising clock edge, change output on falling
// (RULE_24) start is data falling while clock high
// (RULE_25) stop is data rising while clock high; enter standby
// (RULE_26) inputs synchronised; start/stop found from data edges
`timescale 1ns/10ps
module smi_slave #(
    parameter int ADDR_W = smi_pkg::ADDR_W,
    parameter int DEPTH  = smi_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    // serial bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_out,
    // straps and protect
    input  wire logic select_pin_2_in,
    input  wire logic select_pin_1_in,
    input  wire logic select_pin_0_in,
    input  wire logic wp_in,
    // status
    output logic      busy_out
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [5:0] meta;
    logic [5:0] sync;
    logic       scl_d;
    logic       sda_d;
    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic [2:0] sel_s;

    // first stage is read only by the second
    always_ff @(posedge sys_clk_in) begin
        meta <= {scl_in, sda_in, wp_in, select_pin_2_in,
                 select_pin_1_in, select_pin_0_in};
        sync <= meta; // RULE_26
    end
    assign scl_s = sync[5];
    assign sda_s = sync[4];
    assign wp_s  = sync[3];
    assign sel_s = sync[2:0];

    // previous synchronised levels for edge finding
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    // edges are seen two cycles late, so scl must stay far slower
    assign scl_rise  = scl_s && !scl_d; // RULE_23
    assign scl_fall  = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s; // RULE_24
    assign stop_det  = scl_s && scl_d && !sda_d && sda_s; // RULE_25

    // ------------------------------------------------------------
    // byte array and pointer
    // ------------------------------------------------------------
    // no reset on the array: contents survive a bus reset
    logic [7:0]        mem [2**ADDR_W];
    logic [ADDR_W-1:0] ptr; // no reset: persists across frames, RULE_18
    logic [7:0]        rd_byte;

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    smi_pkg::smi_state_t state;
    logic [3:0] bit_cnt;   // 0..7 data bits, 8 = acknowledge slot
    logic [7:0] shreg;
    logic       ack_now;   // pending ack decision for this unit
    logic       wr_valid;
    smi_pkg::smi_wreq_t wr_req;
    logic       fifo_ready;

    // bit counter and shifter; a start or stop resets the framing
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || start_det || stop_det) begin
            bit_cnt <= smi_pkg::BIT_CNT_RST;
        end else if (scl_rise && state != smi_pkg::SMI_IDLE) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1; // RULE_01
        end
    end

    // main sequencer: decisions are made on the 8th and 9th rising edges
    always_ff @(posedge sys_clk_in) begin
        wr_valid <= 1'b0;
        if (rst_in) begin
            state    <= smi_pkg::SMI_IDLE;
            ack_now  <= 1'b0;
            wr_valid <= 1'b0;
        end else if (stop_det) begin
            state   <= smi_pkg::SMI_IDLE; // RULE_03 RULE_25
            ack_now <= 1'b0;
        end else if (start_det) begin
            state   <= smi_pkg::SMI_DEVADR; // RULE_24
            ack_now <= 1'b0;
        end else if (scl_rise && bit_cnt == 4'h7) begin
            // 8th bit arriving now completes the unit
            case (state)
                smi_pkg::SMI_DEVADR: begin
                    if ({shreg[6:0], sda_s} >> smi_pkg::TYPE_POS
                            == 8'(smi_pkg::TYPE_CODE)
                        && shreg[2:0] == sel_s) begin // RULE_05 RULE_07
                        ack_now <= 1'b1; // RULE_12
                    end else begin
                        state <= smi_pkg::SMI_IDLE; // RULE_06
                    end
                end
                smi_pkg::SMI_ADRHI, smi_pkg::SMI_ADRLO,
                smi_pkg::SMI_WDATA: begin
                    ack_now <= 1'b1; // RULE_09 RULE_11
                end
                default: begin
                    ack_now <= 1'b0;
                end
            endcase
        end else if (scl_rise && bit_cnt == 4'h8) begin
            // 9th clock sampled: the unit is finished
            ack_now <= 1'b0;
            case (state)
                smi_pkg::SMI_DEVADR: begin
                    if (shreg[smi_pkg::DIR_POS]) begin // RULE_08
                        state <= smi_pkg::SMI_RDATA; // RULE_17
                    end else begin
                        state <= smi_pkg::SMI_ADRHI;
                    end
                end
                smi_pkg::SMI_ADRHI: begin
                    ptr[ADDR_W-1:8] <= shreg[ADDR_W-9:0]; // RULE_09 RULE_10
                    state           <= smi_pkg::SMI_ADRLO;
                end
                smi_pkg::SMI_ADRLO: begin
                    ptr[7:0] <= shreg; // RULE_19
                    state    <= smi_pkg::SMI_WDATA; // RULE_14
                end
                smi_pkg::SMI_WDATA: begin
                    // commit as the acknowledge completes
                    wr_valid <= !wp_s; // RULE_13 RULE_16
                    wr_req   <= '{addr: ptr, data: shreg};
                    ptr      <= ptr + 1'b1; // RULE_15
                end
                smi_pkg::SMI_RDATA: begin
                    // master ack low: keep sending; high: release
                    ptr <= ptr + 1'b1; // RULE_21
                    if (sda_s) begin
                        state <= smi_pkg::SMI_IDLE; // RULE_04 RULE_20
                    end
                end
                default: begin
                    state <= smi_pkg::SMI_IDLE;
                end
            endcase
        end
    end

    // read data is the byte at the pointer, fetched before each unit
    assign rd_byte = mem[ptr];

    // ------------------------------------------------------------
    // data line driver: changes on a falling clock edge; a start or stop releases it
    // ------------------------------------------------------------
    // a one on the line is a released pin, never a driven high
    logic [7:0] tx_sh;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || stop_det || start_det) begin
            sda_out    <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (scl_fall) begin // RULE_23
            if (bit_cnt == 4'h8 && ack_now) begin
                sda_out    <= 1'b0;
                sda_oe_out <= 1'b1; // RULE_01
            end else if (state == smi_pkg::SMI_RDATA && bit_cnt == 4'h0) begin
                sda_out    <= 1'b0;
                sda_oe_out <= !rd_byte[7]; // open drain: low only
                tx_sh      <= {rd_byte[6:0], 1'b0};
            end else if (state == smi_pkg::SMI_RDATA && bit_cnt < 4'h8) begin
                sda_out    <= 1'b0;
                sda_oe_out <= !tx_sh[7];
                tx_sh      <= {tx_sh[6:0], 1'b0};
            end else begin
                sda_out    <= 1'b0;
                sda_oe_out <= 1'b0; // RULE_02 RULE_04
            end
        end
    end

    // ------------------------------------------------------------
    // write path through the fifo into the array
    // ------------------------------------------------------------
    logic               mem_valid;
    smi_pkg::smi_wreq_t mem_req;
    // drain side never stalls, so the fifo cannot fill up
    smi_fifo #(
        .WIDTH ($bits(smi_pkg::smi_wreq_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (wr_valid),
        .in_data_in    (wr_req),
        .in_ready_out  (fifo_ready),
        .out_valid_out (mem_valid),
        .out_data_out  (mem_req),
        .out_ready_in  (1'b1)
    );

    // array drains one write per cycle, far faster than a serial byte
    always_ff @(posedge sys_clk_in) begin
        if (mem_valid) begin
            mem[mem_req.addr] <= mem_req.data; // RULE_16
        end
    end

    // busy while a frame is in progress or writes are pending
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (state != smi_pkg::SMI_IDLE) || mem_valid
                        || !fifo_ready;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_stop_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        stop_det |=> state == smi_pkg::SMI_IDLE) // RULE_25
        else $error("stop did not return to standby");
    a_drive_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $changed(sda_oe_out) |-> $past(scl_fall || start_det
                                       || stop_det)) // RULE_23
        else $error("data line changed off a falling edge");
    a_wp_block: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        mem_valid |-> !$past(wp_s, 2)) // RULE_13
        else $error("array written while protected");
    a_nack_rel: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (state == smi_pkg::SMI_IDLE && !start_det) |=> !ack_now) // RULE_06
        else $error("acknowledge pending in standby");
    a_ptr_inc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_valid |-> ptr == $past(ptr) + 1'b1) // RULE_15
        else $error("pointer not advanced after write");
    a_idle_free: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (stop_det ##1 !scl_fall [*2]) |-> !sda_oe_out) // RULE_03
        else $error("line held after stop");
    a_ack_nine: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sda_oe_out && bit_cnt == 4'h8 && ack_now) |-> !sda_out) // RULE_01
        else $error("acknowledge not low");
    a_bit_range: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        bit_cnt <= 4'h8) // RULE_11
        else $error("bit counter out of range");
    a_sel_match: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (scl_fall && bit_cnt == 4'h8 && state == smi_pkg::SMI_DEVADR)
        |-> shreg[3:1] == sel_s && shreg[7:4] == smi_pkg::TYPE_CODE) // RULE_07
        else $error("address word acknowledged with wrong code");
    a_rd_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (state == smi_pkg::SMI_RDATA && scl_rise && bit_cnt == 4'h8)
        |-> !sda_oe_out) // RULE_02
        else $error("data line held during read acknowledge");
    a_no_ack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (state == smi_pkg::SMI_IDLE && bit_cnt == 4'h8)
        |-> !sda_oe_out) // RULE_06
        else $error("acknowledge driven while in standby");
endmodule // smi_slave

// ==== verif/smi_master_model.sv ====
// smi_master_model: behavioural two-wire bus master for the memory slave
// assumes the bench resolves sda as open drain with a pull-up
`timescale 1ns/10ps
module smi_master_model (
    // clock
    input  wire logic sys_clk_in,
    // serial bus
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_pull_out
);
    // ------------------------------------------------------------
    // bus timing: a quarter bit is two clocks, so scl runs at 80 ns
    // ------------------------------------------------------------
    // scl parks high between frames, released data floats high
    initial begin
        scl_out      = 1'b1;
        sda_pull_out = 1'b0;
    end

    // steps land on the falling edge, away from the sampling edge
    task automatic qtr();
        repeat (2) @(negedge sys_clk_in);
    endtask

    // start or repeated start: data falls while clock high
    task automatic start();
        sda_pull_out = 1'b0;
        qtr();
        scl_out = 1'b1;
        qtr();
        sda_pull_out = 1'b1;
        qtr();
        scl_out = 1'b0;
        qtr();
    endtask

    // stop: data rises while clock high, clock then stands still
    task automatic stop();
        sda_pull_out = 1'b1;
        qtr();
        scl_out = 1'b1;
        qtr();
        sda_pull_out = 1'b0;
        qtr();
    endtask

    // one bit: data changes only while clock low, sampled mid-high
    task automatic bit_cyc(input logic b, output logic s);
        sda_pull_out = ~b;
        qtr();
        scl_out = 1'b1;
        qtr();
        s = sda_in;
        qtr();
        scl_out = 1'b0;
        qtr();
    endtask

    // send a unit msb first, then release the line for the ack
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], s);
        end
        bit_cyc(1'b1, s);
        ack = ~s;
    endtask

    // take a unit, then ack it or end the read with a not-ack
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, s);
            d[i] = s;
        end
        bit_cyc(~ack, s);
    endtask
endmodule // smi_master_model

// ==== verif/testbench.sv ====
// testbench: scenario tasks for the serial memory slave
// assumes smi_pkg is compiled first and the master model beside it
`timescale 1ns/10ps
module testbench;
    // ------------------------------------------------------------
    // clock, reset, pins
    // ------------------------------------------------------------
    logic       sys_clk_in = 1'b0;
    logic       rst_in     = 1'b1;
    logic       wp         = 1'b0;
    logic [2:0] sel        = 3'h5;
    logic       scl;
    logic       pull;
    logic       sda_o;
    logic       sda_oe;
    logic       busy;
    logic       sda;
    int         fail_count = 0;
    int         num_checks = 0;
    int         cycles     = 0;

    // open drain: either party pulling low wins over the pull-up
    assign sda = ~pull & ~(sda_oe & ~sda_o);
    always #5 sys_clk_in = ~sys_clk_in;

    smi_slave dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .select_pin_2_in(sel[2]), .select_pin_1_in(sel[1]),
        .select_pin_0_in(sel[0]), .wp_in(wp), .busy_out(busy));
    smi_master_model master (
        .sys_clk_in(sys_clk_in), .sda_in(sda), .scl_out(scl),
        .sda_pull_out(pull));

    // ------------------------------------------------------------
    // shared steps
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic addr_word(input logic [3:0] t, input logic [2:0] s,
                             input logic rw, input logic exp);
        logic ack;
        master.wr_byte({t, s, rw}, ack);
        check("address ack", {31'h0, exp}, {31'h0, ack});
    endtask

    task automatic load(input logic [14:0] a);
        logic ack;
        master.start();
        addr_word(smi_pkg::TYPE_CODE, sel, 1'b0, 1'b1);
        master.wr_byte({1'b0, a[14:8]}, ack);
        check("addr high ack", 32'h1, {31'h0, ack});
        master.wr_byte(a[7:0], ack);
        check("addr low ack", 32'h1, {31'h0, ack});
        check("frame busy", 32'h1, {31'h0, busy});
    endtask

    task automatic write_seq(input logic [14:0] a, input logic [31:0] d,
                             input int n);
        logic ack;
        load(a);
        for (int i = 0; i < n; i++) begin
            master.wr_byte(d[31-8*i -: 8], ack);
            check("data ack", 32'h1, {31'h0, ack});
        end
        master.stop();
    endtask

    // cur set: current-address read, no pointer load
    task automatic read_seq(input logic cur, input logic [14:0] a,
                            input int n, output logic [31:0] d);
        logic [7:0] b;
        d = 32'h0;
        if (!cur) begin
            load(a);
        end
        master.start();
        addr_word(smi_pkg::TYPE_CODE, sel, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            master.rd_byte(i < n - 1, b);
            d[31-8*i -: 8] = b;
        end
        master.stop();
    endtask

    // drive and busy must drop once a frame has ended
    task automatic idle_check();
        repeat (4) @(negedge sys_clk_in);
        check("idle drive", 32'h0, {31'h0, sda_oe});
        check("data level", 32'h0, {31'h0, sda_o});
        check("idle busy", 32'h0, {31'h0, busy});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_write_read();
        logic [31:0] d;
        write_seq(15'h1234, 32'h5a000000, 1);
        read_seq(1'b0, 15'h1234, 1, d);
        check("random read", 32'h5a000000, d);
        idle_check();
    endtask

    // page write and sequential read across the top of the array
    task automatic t_wrap();
        logic [31:0] d;
        write_seq(15'h7ffe, 32'hc1c2c3c4, 4);
        read_seq(1'b0, 15'h7ffe, 3, d);
        check("wrap read", 32'hc1c2c300, d);
        read_seq(1'b1, 15'h0, 1, d);
        check("current read", 32'hc4000000, d);
    endtask

    // every select code once, plus a wrong type code
    task automatic t_select();
        for (int i = 0; i < 8; i++) begin
            master.start();
            addr_word(smi_pkg::TYPE_CODE, i[2:0], 1'b0,
                      i[2:0] == sel);
            master.stop();
        end
        master.start();
        addr_word(~smi_pkg::TYPE_CODE, sel, 1'b0, 1'b0);
        master.stop();
        idle_check();
    endtask

    // writes acked but dropped while protected; reads still work
    task automatic t_protect();
        logic [31:0] d;
        wp = 1'b1;
        write_seq(15'h1234, 32'h99000000, 1);
        read_seq(1'b0, 15'h1234, 1, d);
        check("protected", 32'h5a000000, d);
        wp = 1'b0;
    endtask

    // stop in mid data byte must leave the array untouched
    task automatic t_abort();
        logic        s;
        logic [31:0] d;
        load(15'h1234);
        for (int i = 0; i < 4; i++) begin
            master.bit_cyc(1'b0, s);
        end
        master.stop();
        idle_check();
        read_seq(1'b0, 15'h1234, 1, d);
        check("aborted write", 32'h5a000000, d);
    endtask

    // ------------------------------------------------------------
    // verdict and sequence
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 4000 cycles needed
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (5) @(negedge sys_clk_in);
        rst_in = 1'b0;
        repeat (6) @(negedge sys_clk_in);
        t_write_read();
        t_wrap();
        t_select();
        t_protect();
        t_abort();
        end_of_test();
    end
endmodule // testbench
